// ---- include/chc_pkg.sv ----
package chc_pkg;
    // Operating modes of the host port
    typedef enum logic [1:0] {
        CHC_MODE_MEMORY = 2'b00,
        CHC_MODE_IO     = 2'b01,
        CHC_MODE_IDE    = 2'b10
    } chc_mode_type;

    // Ready sequencing states
    typedef enum logic [1:0] {
        CHC_RDY_INIT  = 2'b00,
        CHC_RDY_READY = 2'b01,
        CHC_RDY_BUSY  = 2'b10
    } chc_rdy_type;

    // Raw host control pins, all asynchronous to clk
    typedef struct packed {
        logic iowr_n;
        logic oe_n;
        logic we_n;
        logic attr_sel_n;
        logic stop;
        logic dmack_n;
        logic ide_mode_select_n;
        logic card_reset;
    } chc_pins_type;

    localparam int CHC_PIN_WIDTH = 8;

    // Reset sequencing, init time in ns and derived cycles at 250 MHz
    localparam int CHC_CLK_PERIOD_NS  = 4;
    localparam int CHC_INIT_TIME_NS   = 1000;
    localparam int CHC_INIT_CYCLES    = (CHC_INIT_TIME_NS + CHC_CLK_PERIOD_NS - 1) / CHC_CLK_PERIOD_NS;
    localparam int CHC_CNT_WIDTH      = 16;
    localparam logic [CHC_CNT_WIDTH-1:0] CHC_CNT_RESET = 16'h0000;

    // Pulse-mode interrupt width in cycles
    localparam int CHC_IRQ_PULSE_CYCLES = 4;
    localparam logic [3:0] CHC_IRQ_CNT_RESET = 4'h0;

    // Synchroniser reset value, pins idle high except stop and card reset
    localparam logic [CHC_PIN_WIDTH-1:0] CHC_PIN_IDLE = 8'hF6;
endpackage : chc_pkg

// ---- rtl/chc_sync.sv ----
`timescale 1ns/1ns
// Two-flop synchroniser for a vector of asynchronous pins
module chc_sync #(
    parameter int                WIDTH = 8,
    parameter logic [WIDTH-1:0]  IDLE  = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q   <= IDLE;
            sync_out <= IDLE;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : chc_sync

// ---- rtl/chc_edge.sv ----
`timescale 1ns/1ns
// Falling and rising edge detector on synchronised signals
module chc_edge #(
    parameter int               WIDTH = 8,
    parameter logic [WIDTH-1:0] IDLE  = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] fall,
    output logic      [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] prev_q;

    // Previous sample for edge compare
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= IDLE;
        else
            prev_q <= level_in;
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_edge
            assign fall[i] = prev_q[i] & ~level_in[i];
            assign rise[i] = ~prev_q[i] & level_in[i];
        end
    endgenerate
endmodule : chc_edge

// ---- rtl/chc_host_ctrl.sv ----
`timescale 1ns/1ns
// What this block does
// - In I/O and IDE modes capture host data on each I/O write strobe.
// - In memory mode the I/O write strobe is ignored.
// - In IDE mode an active Ultra DMA burst ends when the host raises stop.
// - In memory mode output enable drives memory, card info and config reads.
// - In I/O mode output enable serves only card info and config reads.
// - A low IDE mode select input places the device in IDE mode.
// - In memory mode ready is high when idle and low while busy.
// - Ready stays low after any reset until initialisation completes.
// - Configured for I/O, interrupts go low as a pulse or a level.
// - In IDE mode the interrupt request is an active-high output.
// - Memory cycles go to common memory when select high, attribute when low.
// - In IDE mode DMA acknowledge is the host's answer to a DMA request.
// - Memory and I/O modes reset while the card reset input is high, once that pin has been seen low since power-up.
// - Setting the soft-reset configuration bit also resets the device.
// - In IDE mode the reset input is an active-low host reset.
// - In IDE mode the device requests DMA by raising its request output.
module chc_host_ctrl #(
    parameter int DATA_WIDTH  = 16,
    parameter int INIT_CYCLES = chc_pkg::CHC_INIT_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  chc_pkg::chc_pins_type      pins,
    input  wire logic [DATA_WIDTH-1:0] host_data,
    input  wire logic                  soft_reset,
    input  wire logic                  io_configured,
    input  wire logic                  irq_level_mode,
    input  wire logic                  irq_event,
    input  wire logic                  irq_clear,
    input  wire logic                  busy,
    input  wire logic                  dma_req,
    input  wire logic                  udma_active,
    output logic      [DATA_WIDTH-1:0] wr_data,
    output logic                       wr_strobe,
    output logic                       rd_strobe,
    output logic                       rd_common,
    output logic                       rd_attr,
    output logic                       wr_common,
    output logic                       wr_attr,
    output logic                       udma_burst_end,
    output logic                       dma_ack,
    output logic                       dmarq,
    output logic                       ready,
    output logic                       card_interrupt_request_n,
    output logic                       intrq,
    output logic [1:0]                 mode,
    output logic                       dev_reset
);
    localparam logic [chc_pkg::CHC_CNT_WIDTH-1:0] INIT_LAST =
        chc_pkg::CHC_CNT_WIDTH'(INIT_CYCLES - 1);
    localparam logic [3:0] IRQ_LOAD = 4'(chc_pkg::CHC_IRQ_PULSE_CYCLES);

    chc_pkg::chc_pins_type pins_s;
    chc_pkg::chc_pins_type pins_f;
    chc_pkg::chc_pins_type pins_r;
    chc_pkg::chc_mode_type mode_q;
    chc_pkg::chc_rdy_type  rdy_q;
    logic [chc_pkg::CHC_CNT_WIDTH-1:0] init_cnt_q;
    logic [3:0]                        irq_cnt_q;
    logic                              irq_pend_q;
    logic                              soft_prev_q;
    logic                              reset_armed_q;
    logic [1:0]                        settle_q;
    logic                              reset_req;
    logic                              is_ide;
    logic                              is_io;
    logic                              is_mem;
    logic [DATA_WIDTH-1:0]             data_q;

    // Pins into clk domain
    chc_sync #(
        .WIDTH (chc_pkg::CHC_PIN_WIDTH),
        .IDLE  (chc_pkg::CHC_PIN_IDLE)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pins),
        .sync_out (pins_s)
    );

    // One pulse per strobe edge
    chc_edge #(
        .WIDTH (chc_pkg::CHC_PIN_WIDTH),
        .IDLE  (chc_pkg::CHC_PIN_IDLE)
    ) u_edge (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (pins_s),
        .fall     (pins_f),
        .rise     (pins_r)
    );

    // Data bus sampled twice to line up with the synchronised strobe
    logic [DATA_WIDTH-1:0] data_m_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_m_q <= '0;
            data_q   <= '0;
        end
        else
        begin
            data_m_q <= host_data;
            data_q   <= data_m_q;
        end
    end

    // Mode from the select pin; IDE when grounded
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= chc_pkg::CHC_MODE_MEMORY;
        else if (!pins_s.ide_mode_select_n)
            mode_q <= chc_pkg::CHC_MODE_IDE;
        else if (io_configured)
            mode_q <= chc_pkg::CHC_MODE_IO;
        else
            mode_q <= chc_pkg::CHC_MODE_MEMORY;
    end

    assign is_ide = (mode_q == chc_pkg::CHC_MODE_IDE);
    assign is_io  = (mode_q == chc_pkg::CHC_MODE_IO);
    assign is_mem = (mode_q == chc_pkg::CHC_MODE_MEMORY);

    // Reset sources: card reset high, IDE reset low, soft-reset rising
    assign reset_req = (is_ide ? ~pins_s.card_reset
                               : (reset_armed_q & pins_s.card_reset))
                     | (soft_reset & ~soft_prev_q);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            soft_prev_q <= 1'b0;
        else
            soft_prev_q <= soft_reset;
    end

    // Card reset counts only once its pin was seen low; a pin tied high resets at power-up only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            settle_q      <= 2'b00;
            reset_armed_q <= 1'b0;
        end
        else
        begin
            settle_q      <= {settle_q[0], 1'b1};
            reset_armed_q <= reset_armed_q | (settle_q[1] & ~pins_s.card_reset); // Synchroniser settled
        end
    end

    // Ready sequencing: hold low through init after any reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdy_q      <= chc_pkg::CHC_RDY_INIT;
            init_cnt_q <= chc_pkg::CHC_CNT_RESET;
        end
        else if (reset_req)
        begin
            rdy_q      <= chc_pkg::CHC_RDY_INIT;
            init_cnt_q <= chc_pkg::CHC_CNT_RESET;
        end
        else
        begin
            case (rdy_q)
                chc_pkg::CHC_RDY_INIT:
                begin
                    if (init_cnt_q == INIT_LAST)
                        rdy_q <= chc_pkg::CHC_RDY_READY;
                    else
                        init_cnt_q <= init_cnt_q + 1'b1;
                end
                chc_pkg::CHC_RDY_READY:
                    if (busy)
                        rdy_q <= chc_pkg::CHC_RDY_BUSY;
                chc_pkg::CHC_RDY_BUSY:
                    if (!busy)
                        rdy_q <= chc_pkg::CHC_RDY_READY;
                default:
                    rdy_q <= chc_pkg::CHC_RDY_INIT;
            endcase
        end
    end

    // Ready output and internal reset, registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready     <= 1'b0;
            dev_reset <= 1'b1;
        end
        else
        begin
            ready     <= (rdy_q == chc_pkg::CHC_RDY_READY) & ~reset_req & ~busy;
            dev_reset <= reset_req | (rdy_q == chc_pkg::CHC_RDY_INIT);
        end
    end

    // Strobes and routing; accesses during init or a reset request are dropped
    logic live;
    assign live = (rdy_q != chc_pkg::CHC_RDY_INIT) & ~reset_req;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_strobe <= 1'b0;
            wr_data   <= '0;
            rd_strobe <= 1'b0;
            rd_common <= 1'b0;
            rd_attr   <= 1'b0;
            wr_common <= 1'b0;
            wr_attr   <= 1'b0;
        end
        else
        begin
            // I/O write captures data, ignored in memory mode
            wr_strobe <= live & ~is_mem & pins_f.iowr_n;
            if (live & ~is_mem & pins_f.iowr_n)
                wr_data <= data_q;
            // Output enable reads
            rd_strobe <= live & (is_mem | (is_io & ~pins_s.attr_sel_n)) & pins_f.oe_n;
            // Common memory only in memory mode; attribute in memory or I/O
            rd_common <= live & is_mem & pins_f.oe_n & pins_s.attr_sel_n;
            rd_attr   <= live & (is_mem | is_io) & pins_f.oe_n
                       & ~pins_s.attr_sel_n;
            wr_common <= live & is_mem & pins_f.we_n & pins_s.attr_sel_n;
            wr_attr   <= live & ~is_ide & pins_f.we_n & ~pins_s.attr_sel_n;
        end
    end

    // Ultra DMA handshake in IDE mode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            udma_burst_end <= 1'b0;
            dma_ack        <= 1'b0;
            dmarq          <= 1'b0;
        end
        else
        begin
            udma_burst_end <= is_ide & udma_active & pins_r.stop;
            dma_ack        <= is_ide & live & ~pins_s.dmack_n;
            dmarq          <= is_ide & live & dma_req;
        end
    end

    // Interrupt pending flag; a new event wins over a clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_pend_q <= 1'b0;
        else if (irq_event)
            irq_pend_q <= 1'b1;
        else if (irq_clear | reset_req)
            irq_pend_q <= 1'b0;
    end

    // Pulse-mode width counter, loaded with the full width so the pin stays low that many cycles
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_cnt_q <= chc_pkg::CHC_IRQ_CNT_RESET;
        else if (irq_event & ~irq_level_mode)
            irq_cnt_q <= IRQ_LOAD;
        else if (irq_cnt_q != chc_pkg::CHC_IRQ_CNT_RESET)
            irq_cnt_q <= irq_cnt_q - 1'b1;
    end

    // Interrupt outputs per mode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            card_interrupt_request_n <= 1'b1;
            intrq                    <= 1'b0;
        end
        else
        begin
            card_interrupt_request_n <= ~(is_io & (irq_level_mode ? irq_pend_q
                                      : (irq_cnt_q != chc_pkg::CHC_IRQ_CNT_RESET)));
            intrq                    <= is_ide & irq_pend_q;
        end
    end

    // Mode reported to the rest of the controller
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mode <= 2'b00;
        else
            mode <= mode_q;
    end
endmodule : chc_host_ctrl

// ---- tb/chc_host_ctrl_checker.sv ----
`timescale 1ns/1ns
// Port-level checks on the host control block
module chc_host_ctrl_checker (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire chc_pkg::chc_pins_type pins,
    input wire logic                  soft_reset,
    input wire logic                  irq_level_mode,
    input wire logic                  busy,
    input wire logic                  dma_req,
    input wire logic                  udma_active,
    input wire logic                  ready,
    input wire logic                  wr_strobe,
    input wire logic                  rd_common,
    input wire logic                  wr_common,
    input wire logic                  udma_burst_end,
    input wire logic                  dmarq,
    input wire logic                  card_interrupt_request_n,
    input wire logic                  intrq,
    input wire logic [1:0]            mode,
    input wire logic                  dev_reset
);
    // One clock domain, one reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_ready_init;
        $rose(rst_n) |-> !ready [*4];
    endproperty
    a_ready_init: assert property (p_ready_init) else $error("ready rose early after reset");
    property p_mem_iowr;
        mode == chc_pkg::CHC_MODE_MEMORY |-> !wr_strobe;
    endproperty
    a_mem_iowr: assert property (p_mem_iowr) else $error("write strobe in memory mode");
    property p_common_mem;
        (rd_common || wr_common) |-> mode == chc_pkg::CHC_MODE_MEMORY;
    endproperty
    a_common_mem: assert property (p_common_mem) else $error("common access outside memory mode");
    property p_stop_ide;
        udma_burst_end |-> mode == chc_pkg::CHC_MODE_IDE && $past(udma_active);
    endproperty
    a_stop_ide: assert property (p_stop_ide) else $error("burst end without active transfer");
    property p_intrq_ide;
        intrq |-> mode == chc_pkg::CHC_MODE_IDE;
    endproperty
    a_intrq_ide: assert property (p_intrq_ide) else $error("intrq outside IDE mode");
    property p_irq_io;
        !card_interrupt_request_n |-> mode == chc_pkg::CHC_MODE_IO;
    endproperty
    a_irq_io: assert property (p_irq_io) else $error("card interrupt outside I/O mode");
    property p_irq_pulse;
        $fell(card_interrupt_request_n) && !irq_level_mode |-> !card_interrupt_request_n [*4] ##1 card_interrupt_request_n;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse width wrong");
    property p_busy;
        busy [*4] |-> !ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready high while busy");
    property p_dmarq;
        mode == chc_pkg::CHC_MODE_IDE && !dev_reset |-> dmarq == $past(dma_req);
    endproperty
    a_dmarq: assert property (p_dmarq) else $error("dmarq does not follow request");
    property p_ide_reset;
        (mode == chc_pkg::CHC_MODE_IDE && !pins.card_reset) [*4] |-> dev_reset && !ready;
    endproperty
    a_ide_reset: assert property (p_ide_reset) else $error("IDE reset pin ignored");
    property p_card_reset;
        !pins.card_reset ##1 (mode != chc_pkg::CHC_MODE_IDE && pins.card_reset) [*4] |-> dev_reset;
    endproperty
    a_card_reset: assert property (p_card_reset) else $error("card reset pin ignored");
    property p_soft;
        $rose(soft_reset) |-> ##[1:3] !ready;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset ignored");
    // Main scenarios reached
    c_common: cover property (rd_common);
    c_burst: cover property (udma_burst_end);
    c_level: cover property ($fell(card_interrupt_request_n) && irq_level_mode);
endmodule : chc_host_ctrl_checker

bind chc_host_ctrl chc_host_ctrl_checker u_chk (.clk(clk), .rst_n(rst_n), .pins(pins), .soft_reset(soft_reset),
    .irq_level_mode(irq_level_mode), .busy(busy), .dma_req(dma_req), .udma_active(udma_active), .ready(ready),
    .wr_strobe(wr_strobe), .rd_common(rd_common), .wr_common(wr_common), .udma_burst_end(udma_burst_end),
    .dmarq(dmarq), .card_interrupt_request_n(card_interrupt_request_n), .intrq(intrq), .mode(mode),
    .dev_reset(dev_reset));

// ---- tb/chc_host_model.sv ----
`timescale 1ns/1ns
// Behavioural host driving the control pins and data bus
module chc_host_model (
    input  wire logic            clk,
    input  wire logic            ready,
    output chc_pkg::chc_pins_type pins,
    output logic [15:0]          host_data
);
    // Idle: strobes high, stop low, IDE select high, card reset low
    initial
    begin
        pins      = 8'hF6;
        host_data = 16'h0000;
    end
    // One host cycle: toggle masked pins for three cycles, then restore
    task automatic cycle(input logic [7:0] mask, input logic attr_n, input logic [15:0] d, output logic late);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        late = (ready !== 1'b1); // Ready never came; the caller counts it
        @(posedge clk);
        #1;
        pins.attr_sel_n = attr_n;
        host_data       = d;
        repeat (2) @(posedge clk);
        #1;
        pins = pins ^ mask;
        repeat (3) @(posedge clk);
        #1;
        pins = pins ^ mask;
        repeat (2) @(posedge clk);
        #1;
        pins.attr_sel_n = 1'b1;
        host_data       = ~d; // Released bus stops showing the last word
    endtask : cycle
endmodule : chc_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
// Self-checking bench for the host control block
module tb_top;
    localparam int INIT = 8;
    logic                  clk, rst_n, soft_reset, io_configured, irq_level_mode, irq_event, irq_clear;
    logic                  busy, dma_req, udma_active, wr_strobe, rd_strobe, rd_common, rd_attr, wr_common;
    logic                  wr_attr, udma_burst_end, dma_ack, dmarq, ready, irq_n, intrq, dev_reset;
    logic [1:0]            mode;
    logic [15:0]           host_data, wr_data;
    logic [6:0]            seen;
    chc_pkg::chc_pins_type pins;
    int                    miscompares, comparisons, n_wr, n;

    chc_host_model u_host (.clk(clk), .ready(ready), .pins(pins), .host_data(host_data));
    chc_host_ctrl #(.DATA_WIDTH(16), .INIT_CYCLES(INIT)) u_dut (.clk(clk), .rst_n(rst_n), .pins(pins),
        .host_data(host_data), .soft_reset(soft_reset), .io_configured(io_configured),
        .irq_level_mode(irq_level_mode), .irq_event(irq_event), .irq_clear(irq_clear), .busy(busy),
        .dma_req(dma_req), .udma_active(udma_active), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rd_common(rd_common), .rd_attr(rd_attr), .wr_common(wr_common),
        .wr_attr(wr_attr), .udma_burst_end(udma_burst_end), .dma_ack(dma_ack), .dmarq(dmarq),
        .ready(ready), .card_interrupt_request_n(irq_n), .intrq(intrq), .mode(mode), .dev_reset(dev_reset));

    // 250 MHz clock
    always #2 clk = ~clk;
    // Gather output pulses between checks
    always @(posedge clk)
    begin
        seen <= seen | {wr_strobe, rd_strobe, rd_common, rd_attr, wr_common, wr_attr, udma_burst_end};
        n_wr <= n_wr + int'(wr_strobe === 1'b1);
    end

    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : step
    // Bounded wait for ready, returning cycles waited
    task automatic wait_ready(output int c);
        c = 0;
        while (ready !== 1'b1)
        begin
            step(1);
            c++;
            if (c > 1000)
            begin
                miscompares++;
                report_and_stop();
            end
        end
    endtask : wait_ready
    // One host cycle, then compare the masked pulses it produced
    task automatic op(input string name, input logic [7:0] pm, input logic a, input logic [15:0] d,
                      input logic [6:0] m, input logic [6:0] exp);
        logic late;
        seen = '0;
        n_wr = 0;
        u_host.cycle(pm, a, d, late);
        if (late)
        begin
            miscompares++;
            report_and_stop();
        end
        step(4);
        check(name, seen & m, exp);
    endtask : op

    // Main sequence
    initial
    begin
        {clk, rst_n, soft_reset, io_configured, irq_level_mode, irq_event, irq_clear} = '0;
        {busy, dma_req, udma_active} = '0;
        {miscompares, comparisons} = '0;
        repeat (12) @(posedge clk);
        check("ready in reset", ready, 0);
        check("dev_reset in reset", dev_reset, 1);
        #1 rst_n = 1'b1;
        wait_ready(n);
        check("init long enough", n >= INIT, 1);
        check("memory mode", mode, chc_pkg::CHC_MODE_MEMORY);
        op("mem iowr", 8'h80, 1'b1, 16'h1234, 7'h7F, 7'h00);
        op("mem oe common", 8'h40, 1'b1, 16'h0000, 7'h3F, 7'h30);
        op("mem oe attr", 8'h40, 1'b0, 16'h0000, 7'h3F, 7'h28);
        op("mem we common", 8'h20, 1'b1, 16'h0000, 7'h3F, 7'h04);
        op("mem we attr", 8'h20, 1'b0, 16'h0000, 7'h3F, 7'h02);
        busy = 1'b1;
        step(6);
        check("ready while busy", ready, 0);
        busy = 1'b0;
        wait_ready(n);
        u_host.pins.card_reset = 1'b1;
        step(6);
        check("card reset", {dev_reset, ready}, 2'b10);
        u_host.pins.card_reset = 1'b0;
        wait_ready(n);
        soft_reset = 1'b1;
        step(3);
        check("soft reset", ready, 0);
        soft_reset = 1'b0;
        wait_ready(n);
        io_configured = 1'b1;
        step(6);
        check("io mode", mode, chc_pkg::CHC_MODE_IO);
        op("io write", 8'h80, 1'b0, 16'hA5C3, 7'h7F, 7'h40);
        check("io write data", wr_data, 16'hA5C3);
        check("io write once", n_wr, 1);
        op("io oe attr", 8'h40, 1'b0, 16'h0000, 7'h3F, 7'h28);
        op("io oe common", 8'h40, 1'b1, 16'h0000, 7'h3F, 7'h00);
        irq_event = 1'b1;
        step(1);
        irq_event = 1'b0;
        n = 0;
        repeat (12)
        begin
            step(1);
            n += int'(irq_n === 1'b0);
        end
        check("irq pulse width", n, 4);
        irq_level_mode = 1'b1;
        irq_event = 1'b1;
        step(1);
        irq_event = 1'b0;
        step(8);
        check("irq level held", irq_n, 0);
        irq_clear = 1'b1;
        step(1);
        irq_clear = 1'b0;
        step(3);
        check("irq level cleared", irq_n, 1);
        u_host.pins.ide_mode_select_n = 1'b0;
        u_host.pins.card_reset = 1'b1;
        step(6);
        wait_ready(n);
        check("ide mode", mode, chc_pkg::CHC_MODE_IDE);
        op("ide write", 8'h80, 1'b1, 16'h5A3C, 7'h7F, 7'h40);
        check("ide write data", wr_data, 16'h5A3C);
        op("stop idle", 8'h08, 1'b1, 16'h0000, 7'h01, 7'h00);
        udma_active = 1'b1;
        op("stop in burst", 8'h08, 1'b1, 16'h0000, 7'h01, 7'h01);
        u_host.pins.dmack_n = 1'b0;
        dma_req = 1'b1;
        step(5);
        check("dma ack and request", {dma_ack, dmarq}, 2'b11);
        u_host.pins.dmack_n = 1'b1;
        dma_req = 1'b0;
        irq_event = 1'b1;
        step(1);
        irq_event = 1'b0;
        step(2);
        check("intrq high", {intrq, irq_n}, 2'b11);
        u_host.pins.card_reset = 1'b0;
        step(6);
        check("ide reset", {dev_reset, ready}, 2'b10);
        report_and_stop();
    end
endmodule : tb_top
